// File: hw/wavegen_pkg.sv
// constants, register map and state encoding of the waveform generator
package wavegen_pkg;
    // ==============================
    // register map, byte addresses
    localparam int DW = 32;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_CFG  = 8'h04;
    localparam logic [7:0] A_AMPL = 8'h08;
    localparam logic [7:0] A_OFFS = 8'h0c;
    localparam logic [7:0] A_FREQ = 8'h10;
    localparam logic [7:0] A_T1   = 8'h14;
    localparam logic [7:0] A_T2   = 8'h18;
    localparam logic [7:0] A_STU  = 8'h1c;
    localparam logic [7:0] A_STI  = 8'h20;
    localparam logic [7:0] A_STP  = 8'h24;
    localparam logic [7:0] A_STAT = 8'h28;

    // ==============================
    // field positions
    localparam int B_ENTER = 0;
    localparam int B_LEAVE = 1;
    localparam int B_START = 2;
    localparam int B_STOP  = 3;
    localparam int B_WAVE  = 0;
    localparam int B_TARG  = 1;
    localparam int B_DCON  = 0;
    localparam int B_RUN   = 1;
    localparam int B_VIEW  = 2;
    localparam int B_CR    = 3;
    localparam int B_ALARM = 4;

    // ==============================
    // value ranges
    localparam logic [15:0] FULL_SCALE = 16'hcccc;
    localparam logic [31:0] FREQ_MIN   = 32'h1;
    localparam logic [31:0] FREQ_MAX   = 32'h2710;
    localparam logic [31:0] T_MIN      = 32'h1;
    localparam logic [31:0] T_MAX      = 32'h15752a00;

    // ==============================
    // timing
    localparam int CLK_NS = 5;
    localparam int TICK_NS = 10000;
    localparam int TICK_CYCLES = TICK_NS / CLK_NS;
    localparam logic [10:0] TICK_LAST = 11'(TICK_CYCLES - 1);
    localparam int UNIT_NS = 100000;
    localparam logic [31:0] TICKS_PER_UNIT = 32'(UNIT_NS / TICK_NS);
    localparam longint TICK_HZ = 1000000000 / TICK_NS;
    localparam logic [31:0] PHASE_PER_HZ = 32'((64'h1 << 32) / TICK_HZ);

    // ==============================
    // reset values and states
    localparam logic [15:0] RST_FREQ = 16'h0001;
    localparam logic [31:0] RST_T    = 32'h00000001;
    typedef enum logic [2:0] {
        ST_CONFIG = 3'b001,
        ST_VIEW   = 3'b010,
        ST_RUN    = 3'b100
    } run_state_t;
endpackage

// File: hw/setpoint_waveform_generator.sv
// waveform set-value generator with its ahb-lite register slave
// ==============================
// How it works
// RULE1 - resistance mode blocks every generator register, command and the button; the status register stays readable and its alarm clear works
// RULE2 - generated values are quantised to a full scale of 52428 steps
// RULE3 - no minimum slope, each time accepts up to 36000 seconds
// RULE4 - voltage, current, power always set; one is the waveform, others static
// RULE5 - generated current is capped at the level the power limit allows
// RULE6 - voltage waveform never goes below the static voltage
// RULE7 - static voltage, current and power are forwarded to slave units
// RULE8 - wave and target selection accepted only while the dc input is off
// RULE9 - entering run view switches dc input on with static values applied
// RULE10 - static values, amplitude and offset change freely, even during a run
// RULE11 - screen start runs; button starts only while dc input is off
// RULE12 - screen stop halts the wave, dc input stays on with statics
// RULE13 - button during a run halts the wave and switches dc off
// RULE14 - any alarm or trip stops, switches dc off and reports
// RULE15 - sine frequency is fixed, from 1 Hz to 10000 Hz
// RULE16 - sine is offset plus amplitude times sine; offset, amplitude mutually limited
// RULE17 - triangle rises over t1, falls over t2, each 0.1 ms steps
// RULE18 - triangle period is t1 plus t2, offset is the foot
// RULE19 - output updates once per fixed tick, accumulators advance per tick
// RULE20 - after a stop the output returns to static within one tick
//
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
module setpoint_waveform_generator (
    input  wire logic                      clk,
    input  wire logic                      nrst,
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [wavegen_pkg::DW-1:0] hwdata,
    input  wire logic                      hready,
    output logic                           hreadyout,
    output logic                           hresp,
    output logic [wavegen_pkg::DW-1:0]     hrdata,
    input  wire logic                      constantResistanceMode,
    input  wire logic                      onOffButton,
    input  wire logic                      deviceAlarm,
    input  wire logic                      overpowerProtection,
    input  wire logic                      overcurrentProtection,
    input  wire logic                      eventAlarm,
    input  wire logic [15:0]               inputVoltage,
    output logic                           dcInputOn,
    output logic                           waveRunning,
    output logic                           alarmReport,
    output logic [15:0]                    setVoltage,
    output logic [15:0]                    setCurrent,
    output logic [15:0]                    setPower,
    output logic [15:0]                    slaveVoltage,
    output logic [15:0]                    slaveCurrent,
    output logic [15:0]                    slavePower
);
    import wavegen_pkg::*;

    // ==============================
    // state of the block
    typedef struct packed {
        run_state_t  fsm;
        logic        dcOn, alarm, wave, target;
        logic [15:0] amp, off, freq;
        logic [31:0] t1, t2;
        logic [15:0] statU, statI, statP;
        logic [10:0] tickCnt;
        logic [31:0] phase, elap;
        logic        seg;
        logic [15:0] setU, setI, setP;
        logic        btnMeta, btnSync, btnPrev;
        logic [3:0]  almMeta, almSync;
        logic        crMeta, crSync;
        logic [15:0] vMeta, vSync;
        logic        aWr;
        logic [7:0]  aAddr;
        logic [31:0] rdata;
    } state_t;

    localparam state_t RST = '{fsm: ST_CONFIG, freq: RST_FREQ, t1: RST_T,
                               t2: RST_T, default: '0};

    state_t s;
    state_t n;

    logic        tick, running, cr, btnEdge, alarmAny, wrOk;
    logic        cmdEnter, cmdLeave, cmdStart, cmdStop, goRun;
    logic [1:0]  quad;
    logic [3:0]  tIdx;
    logic [15:0] mag;
    logic [31:0] sProd;
    logic [17:0] sVal;
    logic [31:0] segT;
    logic [15:0] frac;
    logic [17:0] tVal;
    logic [17:0] rawGen;
    logic [15:0] genVal;
    logic [31:0] pQuot;
    logic [15:0] iCap;
    logic [31:0] phaseInc;

    // ==============================
    // helpers
    // quarter sine, q15; the mirrored quadrant reuses it, a tiny asymmetry
    function automatic logic [15:0] sinQ15(input logic [3:0] i);
        case (i)
            4'h0: sinQ15 = 16'h0000;
            4'h1: sinQ15 = 16'h0c8c;
            4'h2: sinQ15 = 16'h18f9;
            4'h3: sinQ15 = 16'h2528;
            4'h4: sinQ15 = 16'h30fb;
            4'h5: sinQ15 = 16'h3c56;
            4'h6: sinQ15 = 16'h471c;
            4'h7: sinQ15 = 16'h5133;
            4'h8: sinQ15 = 16'h5a82;
            4'h9: sinQ15 = 16'h62f1;
            4'ha: sinQ15 = 16'h6a6d;
            4'hb: sinQ15 = 16'h70e2;
            4'hc: sinQ15 = 16'h7641;
            4'hd: sinQ15 = 16'h7a7c;
            4'he: sinQ15 = 16'h7d89;
            default: sinQ15 = 16'h7f61;
        endcase
    endfunction

    // clamp a written word into a range
    function automatic logic [31:0] lim(input logic [31:0] v,
                                        input logic [31:0] lo,
                                        input logic [31:0] hi);
        lim = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // ==============================
    // decoded events
    assign tick     = s.tickCnt == TICK_LAST;
    assign running  = s.fsm == ST_RUN;
    assign cr       = s.crSync;
    assign btnEdge  = s.btnSync && !s.btnPrev && !cr; // RULE1
    assign alarmAny = |s.almSync;
    assign wrOk     = s.aWr && (!cr || s.aAddr == A_STAT); // RULE1
    assign cmdEnter = wrOk && s.aAddr == A_CTRL && hwdata[B_ENTER];
    assign cmdLeave = wrOk && s.aAddr == A_CTRL && hwdata[B_LEAVE];
    assign cmdStart = wrOk && s.aAddr == A_CTRL && hwdata[B_START];
    assign cmdStop  = wrOk && s.aAddr == A_CTRL && hwdata[B_STOP];

    // sine sample: offset plus amplitude times sine
    assign quad     = s.phase[31:30];
    assign tIdx     = quad[0] ? ~s.phase[29:26] : s.phase[29:26];
    assign mag      = sinQ15(tIdx);
    assign sProd    = 32'(s.amp) * 32'(mag);
    assign sVal     = quad[1] ? 18'(s.off) - 18'(sProd[30:15])
                              : 18'(s.off) + 18'(sProd[30:15]); // RULE16
    assign phaseInc = 32'(s.freq) * PHASE_PER_HZ; // RULE15

    // triangle sample: rise over t1 from the foot, fall over t2
    assign segT = 32'((s.seg ? s.t2 : s.t1) * TICKS_PER_UNIT); // RULE17
    assign frac = 16'((48'(s.amp) * 48'(s.elap)) / 48'(segT));
    assign tVal = s.seg ? 18'(s.off) + 18'(s.amp) - 18'(frac)
                        : 18'(s.off) + 18'(frac); // RULE18

    // quantise to the full scale; negative sine troughs clip at zero
    assign rawGen = s.wave ? tVal : sVal;
    assign genVal = rawGen[17] ? 16'h0000
                  : ((rawGen > 18'(FULL_SCALE)) ? FULL_SCALE : rawGen[15:0]); // RULE2

    // current allowed by the power limit at the present input voltage
    assign pQuot = (s.vSync == 16'h0000) ? 32'(FULL_SCALE)
                 : (32'(s.statP) * 32'(FULL_SCALE)) / 32'(s.vSync);
    assign iCap  = (pQuot > 32'(FULL_SCALE)) ? FULL_SCALE : pQuot[15:0]; // RULE5

    // ==============================
    // next state
    always_comb begin
        n = s;
        goRun = 1'b0;
        // pins pass two flops; only the second is read
        n.btnMeta = onOffButton;
        n.btnSync = s.btnMeta;
        n.btnPrev = s.btnSync;
        n.almMeta = {deviceAlarm, overpowerProtection, overcurrentProtection, eventAlarm};
        n.almSync = s.almMeta;
        n.crMeta  = constantResistanceMode;
        n.crSync  = s.crMeta;
        n.vMeta   = inputVoltage;
        n.vSync   = s.vMeta;
        n.tickCnt = tick ? 11'h000 : s.tickCnt + 11'h001; // RULE19
        n.aWr     = 1'b0;
        n.rdata   = 32'h0;

        // register writes in the data phase
        if (wrOk) begin
            case (s.aAddr)
                A_CFG: begin
                    if (!s.dcOn) begin // RULE8
                        n.wave   = hwdata[B_WAVE];
                        n.target = hwdata[B_TARG];
                    end
                end
                A_AMPL: n.amp = 16'(lim(hwdata, 32'h0, 32'(FULL_SCALE - s.off))); // RULE16 RULE10
                A_OFFS: n.off = 16'(lim(hwdata, 32'h0, 32'(FULL_SCALE - s.amp))); // RULE16 RULE10
                A_FREQ: if (!s.dcOn) n.freq = 16'(lim(hwdata, FREQ_MIN, FREQ_MAX)); // RULE15
                A_T1:   if (!s.dcOn) n.t1 = lim(hwdata, T_MIN, T_MAX); // RULE3 RULE17
                A_T2:   if (!s.dcOn) n.t2 = lim(hwdata, T_MIN, T_MAX); // RULE3 RULE17
                A_STU:  n.statU = 16'(lim(hwdata, 32'h0, 32'(FULL_SCALE))); // RULE10
                A_STI:  n.statI = 16'(lim(hwdata, 32'h0, 32'(FULL_SCALE))); // RULE10
                A_STP:  n.statP = 16'(lim(hwdata, 32'h0, 32'(FULL_SCALE))); // RULE10
                A_STAT: if (hwdata[B_ALARM]) n.alarm = 1'b0;
                default: n.alarm = s.alarm;
            endcase
        end

        // waveform accumulators, one step per tick
        if (running && tick) begin // RULE19
            if (!s.wave) begin
                n.phase = s.phase + phaseInc;
            end else if (s.elap >= segT - 32'h1) begin // RULE18
                n.elap = 32'h0;
                n.seg  = !s.seg;
            end else begin
                n.elap = s.elap + 32'h1;
            end
        end

        // run control
        case (s.fsm)
            ST_CONFIG: begin
                if (cmdEnter && !alarmAny) begin // RULE9
                    n.fsm  = ST_VIEW;
                    n.dcOn = 1'b1;
                end
            end
            ST_VIEW: begin
                if (cmdLeave) begin
                    n.fsm  = ST_CONFIG;
                    n.dcOn = 1'b0;
                end else if (cmdStart && !alarmAny) begin // RULE11
                    goRun = 1'b1;
                end else if (btnEdge && !s.dcOn && !alarmAny) begin // RULE11
                    goRun = 1'b1;
                end else if (btnEdge) begin
                    n.dcOn = 1'b0;
                end
            end
            ST_RUN: begin
                if (cmdLeave) begin
                    n.fsm  = ST_CONFIG;
                    n.dcOn = 1'b0;
                end else if (cmdStop) begin // RULE12
                    n.fsm = ST_VIEW;
                end else if (btnEdge) begin // RULE13
                    n.fsm  = ST_VIEW;
                    n.dcOn = 1'b0;
                end
            end
            default: n.fsm = ST_CONFIG;
        endcase
        if (goRun) begin
            n.fsm   = ST_RUN;
            n.dcOn  = 1'b1;
            n.phase = 32'h0;
            n.elap  = 32'h0;
            n.seg   = 1'b0;
        end
        // alarms beat every command; the sticky set beats a clear
        if (alarmAny) begin // RULE14
            n.dcOn  = 1'b0;
            n.alarm = 1'b1;
            if (running) n.fsm = ST_VIEW;
        end

        // set values to the power stage
        n.setP = s.statP; // RULE4
        if (!running) begin // RULE20 RULE12
            n.setU = s.statU;
            n.setI = s.statI;
        end else if (!s.target) begin
            n.setI = s.statI; // RULE4
            if (tick) n.setU = (genVal > s.statU) ? genVal : s.statU; // RULE6
        end else begin
            n.setU = s.statU; // RULE4
            if (tick) n.setI = (genVal > iCap) ? iCap : genVal; // RULE5
        end

        // address phase; read data taken from the updated copy
        if (hsel && htrans[1] && hready) begin
            n.aWr   = hwrite && haddr[31:8] == 24'h0;
            n.aAddr = haddr[7:0];
            if (!hwrite && haddr[31:8] == 24'h0 && (!cr || haddr[7:0] == A_STAT)) begin // RULE1
                case (haddr[7:0])
                    A_CFG: begin
                        n.rdata[B_WAVE] = n.wave;
                        n.rdata[B_TARG] = n.target;
                    end
                    A_AMPL: n.rdata = 32'(n.amp);
                    A_OFFS: n.rdata = 32'(n.off);
                    A_FREQ: n.rdata = 32'(n.freq);
                    A_T1:   n.rdata = n.t1;
                    A_T2:   n.rdata = n.t2;
                    A_STU:  n.rdata = 32'(n.statU);
                    A_STI:  n.rdata = 32'(n.statI);
                    A_STP:  n.rdata = 32'(n.statP);
                    A_STAT: begin
                        n.rdata[B_DCON]  = n.dcOn;
                        n.rdata[B_RUN]   = n.fsm == ST_RUN;
                        n.rdata[B_VIEW]  = n.fsm != ST_CONFIG;
                        n.rdata[B_CR]    = cr;
                        n.rdata[B_ALARM] = n.alarm;
                    end
                    default: n.rdata = 32'h0;
                endcase
            end
        end
    end

    // the one state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= RST;
        end else begin
            s <= n;
        end
    end

    // ==============================
    // outputs
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign hrdata       = s.rdata;
    assign dcInputOn    = s.dcOn;
    assign waveRunning  = running;
    assign alarmReport  = s.alarm;
    assign setVoltage   = s.setU;
    assign setCurrent   = s.setI;
    assign setPower     = s.setP;
    // limits follow the statics so slaves never fight the run
    assign slaveVoltage = s.statU; // RULE7
    assign slaveCurrent = s.statI; // RULE7
    assign slavePower   = s.statP; // RULE7

    // ==============================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_CR_BLOCK: // RULE1
    assert property ((s.aWr && cr && s.aAddr == A_AMPL) |=> $stable(s.amp))
        else $error("amplitude written in resistance mode");
    AST_QUANT: // RULE2
    assert property (s.setU <= FULL_SCALE && s.setI <= FULL_SCALE)
        else $error("set value beyond full scale");
    AST_T_FULL: // RULE3
    assert property ((wrOk && s.aAddr == A_T1 && !s.dcOn && hwdata <= T_MAX
                      && hwdata >= T_MIN) |=> (s.t1 == $past(hwdata)))
        else $error("segment time not taken in full");
    AST_STATIC_LIM: // RULE4
    assert property ((running && !s.target) |=> (s.setI == $past(s.statI)
                      && s.setP == $past(s.statP)))
        else $error("limit set values not static");
    AST_POWER_CAP: // RULE5
    assert property ((running && s.target && tick) |=> (s.setI <= $past(iCap)))
        else $error("current above power limit");
    AST_VOLT_FLOOR: // RULE6
    assert property ((running && !s.target && tick) |=> (s.setU >= $past(s.statU)))
        else $error("voltage below static value");
    AST_CFG_LOCK: // RULE8
    assert property ((wrOk && s.aAddr == A_CFG && s.dcOn) |=> $stable({s.wave, s.target}))
        else $error("selection changed with dc on");
    AST_VIEW_ON: // RULE9
    assert property ((s.fsm == ST_CONFIG && cmdEnter && !alarmAny)
                     |=> (s.dcOn && s.fsm == ST_VIEW) ##1 (s.setU == $past(s.statU)))
        else $error("run view did not apply statics");
    AST_BTN_STOP: // RULE13
    assert property ((running && btnEdge && !cmdStop && !cmdLeave)
                     |=> (!s.dcOn && s.fsm == ST_VIEW))
        else $error("button did not stop and switch off");
    AST_ALARM: // RULE14
    assert property (alarmAny |=> (!s.dcOn && s.fsm != ST_RUN && s.alarm))
        else $error("alarm did not stop the run");
    AST_STOP_STATIC: // RULE12 RULE20
    assert property ((running && cmdStop && !alarmAny && !cmdLeave)
                     |=> (s.dcOn && s.fsm == ST_VIEW) ##1
                         (s.setU == $past(s.statU) && s.setI == $past(s.statI)))
        else $error("stop did not restore statics");
    AST_TICK: // RULE19
    assert property (tick |=> (s.tickCnt == 11'h000) ##1 (!tick) [*8])
        else $error("update tick spacing wrong");
    AST_TRI_SEG: // RULE18
    assert property ((running && s.wave && tick && s.elap >= segT - 32'h1)
                     |=> (s.elap == 32'h0 && s.seg != $past(s.seg)))
        else $error("triangle segment did not turn");

    COV_RUN:    cover property (s.fsm == ST_VIEW ##1 s.fsm == ST_RUN);
    COV_ALARM:  cover property (running && alarmAny);
    COV_BTNRUN: cover property (s.fsm == ST_VIEW && !s.dcOn && btnEdge ##1 running);
    COV_TRI:    cover property (running && s.wave && $changed(s.seg));
endmodule

// File: dv/power_stage_model.sv
// stand-in for the power stage that reports the measured dc input voltage
module power_stage_model #(
    parameter logic [15:0] SOURCE_V = 16'h6666
) (
    output logic [15:0] inputVoltage
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==============================
    // measurement
    // stiff source: no sag under load, keeps the power cap exact but hides sag
    assign inputVoltage = SOURCE_V;
endmodule

// File: dv/tb_top.sv
// self-checking bench of the waveform generator over its register bus and pins
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import wavegen_pkg::*;
    // ==============================
    // signals
    logic        clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, rdPhase = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seed = 32'h8df5, v;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [3:0]  alarms = 4'h0;
    logic        constantResistanceMode = 1'b0, onOffButton = 1'b0;
    logic        hreadyout, hresp, dcInputOn, waveRunning, alarmReport;
    logic [15:0] inputVoltage, setVoltage, setCurrent, setPower;
    logic [15:0] slaveVoltage, slaveCurrent, slavePower;
    logic [31:0] expq[$];
    int          miscompares = 0, n_tests = 0, cycles = 0;

    setpoint_waveform_generator setpoint_waveform_generator_i (
        .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .constantResistanceMode(constantResistanceMode), .onOffButton(onOffButton),
        .deviceAlarm(alarms[0]), .overpowerProtection(alarms[1]),
        .overcurrentProtection(alarms[2]), .eventAlarm(alarms[3]),
        .inputVoltage(inputVoltage), .dcInputOn(dcInputOn), .waveRunning(waveRunning),
        .alarmReport(alarmReport), .setVoltage(setVoltage), .setCurrent(setCurrent),
        .setPower(setPower), .slaveVoltage(slaveVoltage), .slaveCurrent(slaveCurrent),
        .slavePower(slavePower)
    );
    power_stage_model power_stage_model_i (.inputVoltage(inputVoltage));

    // ==============================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // single ahb-lite word transfer; address held until hready, then data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rdPhase <= !w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rdPhase <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    // pins are synced by two flops, so hold the press well past that
    task automatic press;
        onOffButton <= 1'b1;
        cyc(6);
        onOffButton <= 1'b0;
        cyc(6);
    endtask
    // sample settled, then hand back on an edge so later drives stay edge-aligned
    task automatic st(input logic [2:0] e);
        #1;
        check({29'h0, alarmReport, waveRunning, dcInputOn}, {29'h0, e});
        @(posedge clk);
    endtask

    // ==============================
    // clock, timeout and read monitor
    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            finish_test();
        end
    end
    // read data stands one cycle only, so it is taken in its data phase
    always @(posedge clk) begin
        if (rdPhase === 1'b1 && hreadyout === 1'b1) begin
            check(hrdata, expq.pop_front());
            check({31'h0, hresp}, 32'h0);
        end
    end

    // ==============================
    // scenarios
    initial begin
        cyc(10);
        nrst <= 1'b1;
        rd(A_FREQ, FREQ_MIN);
        rd(A_T1, T_MIN);
        rd(A_STAT, 32'h0);
        rd(8'h2c, 32'h0);
        // both ends of frequency and time ranges
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, k[1] ? A_T2 : A_FREQ, k[0] ? 32'hffffffff : 32'h0);
            rd(k[1] ? A_T2 : A_FREQ, k[0] ? (k[1] ? T_MAX : FREQ_MAX) : 32'h1);
        end
        bus(1'b1, A_OFFS, 32'h4000);
        bus(1'b1, A_AMPL, 32'hffff);
        rd(A_AMPL, 32'h8ccc);
        bus(1'b1, A_AMPL, 32'h0);
        for (int k = 0; k < 6; k++) begin
            seed = xs(seed);
            v = {16'h0, seed[15:0]};
            bus(1'b1, A_STU + 8'(4 * (k % 3)), v);
            rd(A_STU + 8'(4 * (k % 3)), v > 32'hcccc ? 32'hcccc : v);
        end
        bus(1'b1, A_CFG, 32'h2);
        bus(1'b1, A_STU, 32'h200);
        bus(1'b1, A_STI, 32'h100);
        bus(1'b1, A_STP, 32'h1000);
        cyc(2);
        #1;
        check({slaveVoltage, slaveCurrent}, 32'h02000100);
        check({setPower, slavePower}, 32'h10001000);
        $display("test registers done");
        // view with dc on refuses a new selection
        bus(1'b1, A_CTRL, 32'h1);
        cyc(2);
        st(3'b001);
        check({16'h0, setCurrent}, 32'h100);
        rd(A_STAT, 32'h5);
        bus(1'b1, A_CFG, 32'h0);
        rd(A_CFG, 32'h2);
        // zero-amplitude current sine sits on its offset, cut by the power cap
        bus(1'b1, A_CTRL, 32'h4);
        cyc(2);
        st(3'b011);
        cyc(2 * TICK_CYCLES + 10);
        #1;
        check({setVoltage, setCurrent}, 32'h02002000);
        bus(1'b1, A_CTRL, 32'h8);
        cyc(2);
        st(3'b001);
        check({16'h0, setCurrent}, 32'h100);
        $display("test run control done");
        press();
        st(3'b000);
        press();
        st(3'b011);
        press();
        st(3'b000);
        // voltage wave below the static voltage leaves the output unchanged
        bus(1'b1, A_CFG, 32'h0);
        bus(1'b1, A_STU, 32'h8000);
        bus(1'b1, A_CTRL, 32'h4);
        cyc(2 * TICK_CYCLES + 10);
        #1;
        check({16'h0, setVoltage}, 32'h8000);
        st(3'b011);
        for (int k = 0; k < 4; k++) begin
            alarms <= 4'(1 << k);
            cyc(5);
            st(3'b100);
            alarms <= 4'h0;
            cyc(4);
            bus(1'b1, A_STAT, 32'h10);
            cyc(2);
            st(3'b000);
            press();
            st(3'b011);
        end
        // triangle on the voltage, one time unit per slope, foot at the offset
        press();
        st(3'b000);
        bus(1'b1, A_CFG, 32'h1);
        bus(1'b1, A_STU, 32'h0);
        bus(1'b1, A_AMPL, 32'h1000);
        bus(1'b1, A_T1, T_MIN);
        bus(1'b1, A_T2, T_MIN);
        bus(1'b1, A_CTRL, 32'h4);
        for (int k = 0; k <= TICKS_PER_UNIT; k++) begin
            @(setVoltage);
            #1;
            check({16'h0, setVoltage}, 32'h4000 + 32'h1000 * k / TICKS_PER_UNIT);
        end
        cyc(1);
        $display("test triangle done");
        constantResistanceMode <= 1'b1;
        press();
        bus(1'b1, A_AMPL, 32'h10);
        rd(A_AMPL, 32'h0);
        rd(A_STAT, 32'hf);
        st(3'b011);
        $display("test alarms and lockout done");
        finish_test();
    end
endmodule
